// ---- core/sms_apb.sv ----
// Purpose: APB slave framing for the status block register file
// Assumes: Register decode done by the caller through hit
// Notes: Read data captured in setup; a frozen setup costs one wait state
`timescale 1ns/1ps
module sms_apb (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Decode from caller
  input wire logic hit,
  input wire logic [sms_pkg::DATA_W-1:0] rd_data,
  // APB answer
  output logic pready,
  output logic pslverr,
  output logic [sms_pkg::DATA_W-1:0] prdata,
  // Write strobe toward the register file
  output logic wr_stb
);

  logic [sms_pkg::DATA_W-1:0] prdata_q;
  logic cap_q;
  // Capture once per read; a setup lost to a frozen edge is redone in access
  wire rd_cap = psel && !pwrite && !cap_q;
  wire access = psel && penable;

  // Stall while frozen so no write slips through a gated edge
  // A read answers only once its data has really been captured
  assign pready = pce && (pwrite || cap_q);
  assign pslverr = access && !hit;
  assign wr_stb = access && pwrite && hit && pce;
  assign prdata = prdata_q;

  // Sample read data in setup; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= sms_pkg::WORD_RST;
      cap_q <= 1'b0;
    end
    else if (pce)
    begin
      cap_q <= psel && !pwrite && !(penable && cap_q);
      if (rd_cap)
        prdata_q <= hit ? rd_data : sms_pkg::WORD_RST;
    end
  end

endmodule : sms_apb

// ---- core/sms_irq.sv ----
// Purpose: Sticky event bits, mask and one level interrupt
// Assumes: Events are one-cycle pulses on pclk
// Notes: Write one to clear; a new event beats a clear in the same cycle
`timescale 1ns/1ps
module sms_irq #(
  parameter int W = 4
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // Events and software access
  input wire logic [W-1:0] evt,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [W-1:0] wdata,
  // State and interrupt
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  logic [W-1:0] sts_q;
  logic [W-1:0] msk_q;

  // One sticky flag per event bit
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    wire clr = clr_we && wdata[i];
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        sts_q[i] <= 1'b0;
      else if (pce)
        sts_q[i] <= evt[i] | (sts_q[i] & ~clr);
    end
  end

  // Mask register, same layout as the status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      msk_q <= '0;
    else if (pce && mask_we)
      msk_q <= wdata;
  end

  assign status = sts_q;
  assign mask = msk_q;
  assign irq = |(sts_q & msk_q);

endmodule : sms_irq

// ---- core/sms_status_top.sv ----
// Purpose: Run/stop, halted and idle status of the stream-to-memory channel
// Assumes: Engine status inputs are on pclk; APB slave for software access
// Notes: SG_PRESENT selects scatter-gather (1) or simple mode (0)
// How it works
// - status word at 0x34, read-only, writes change nothing
// - bit 0 is halted, 1 when stopped, 1 after reset
// - scatter-gather halt needs run cleared, mover and fetch both quiet
// - simple mode halt needs run cleared and mover quiet, may lag
// - halted with run cleared, pointer writes start no activity
// - halted in simple mode, length writes start no transfer
// - bit 1 idle in scatter-gather when tail reached and all done
// - tail pointer write resumes processing when channel is idle
// - simple mode idle once transfer done, zero while in progress
// - idle reads zero whenever halted reads one
// - simple mode idle stays zero until a first transfer issued
// - status bit 2 reserved, reads zero, writes ignored
// - errors clear run, wind down, then halted sets
`timescale 1ns/1ps
module sms_status_top #(
  parameter bit SG_PRESENT = 1'b1
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sms_pkg::ADDR_W-1:0] paddr,
  input wire logic [sms_pkg::DATA_W-1:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [sms_pkg::DATA_W-1:0] prdata,
  // Engine side
  input wire sms_pkg::sms_eng_sts_s eng_sts,
  output sms_pkg::sms_eng_ctl_s eng_ctl,
  output logic [sms_pkg::DATA_W-1:0] cur_ptr,
  output logic [sms_pkg::DATA_W-1:0] tail_ptr,
  output logic [sms_pkg::DATA_W-1:0] xfer_len,
  // Interrupt
  output logic irq
);

  // State
  logic run_q, run_d;
  logic halted_q, halted_d;
  logic idle_q, idle_d;
  logic issued_q, issued_d;
  logic active_q, active_d;
  logic resume_q, cur_load_q, start_q;
  logic [sms_pkg::DATA_W-1:0] cur_q, tail_q, len_q;
  logic [sms_pkg::DATA_W-1:0] rd_data;
  logic [sms_pkg::IRQ_W-1:0] irq_sts, irq_msk, evt;
  logic wr_stb;

  // Address decode
  wire hit_ctl = paddr == sms_pkg::OFF_CTL;
  wire hit_sts = paddr == sms_pkg::OFF_STS;
  wire hit_cur = paddr == sms_pkg::OFF_CUR;
  wire hit_tail = paddr == sms_pkg::OFF_TAIL;
  wire hit_len = paddr == sms_pkg::OFF_LEN;
  wire hit_isr = paddr == sms_pkg::OFF_IRQ_STS;
  wire hit_imr = paddr == sms_pkg::OFF_IRQ_MSK;
  wire hit = hit_ctl | hit_sts | hit_cur | hit_tail | hit_len |
             hit_isr | hit_imr;

  // Write strobes; the status word has none at all
  wire wr_ctl = wr_stb && hit_ctl;
  wire wr_cur = wr_stb && hit_cur;
  wire wr_tail = wr_stb && hit_tail;
  wire wr_len = wr_stb && hit_len;
  wire wr_isr = wr_stb && hit_isr;
  wire wr_imr = wr_stb && hit_imr;

  // Engine conditions
  wire err_any = eng_sts.err_int | eng_sts.err_slv;
  // Fetch activity only counts when the gather engine is built in
  wire quiet = !eng_sts.mover_busy &&
               (!SG_PRESENT || !eng_sts.fetch_busy);
  // Halted with run cleared blocks pointer and length side effects
  wire frozen = halted_q && !run_q;
  wire may_start = run_q && !halted_q;

  // Run bit: errors win over a software set in the same cycle
  assign run_d = err_any ? 1'b0 :
                 wr_ctl ? pwdata[sms_pkg::CTL_RUN_BIT] : run_q;

  // Halted: clears on run, sets only after wind-down completes
  assign halted_d = run_q ? 1'b0 :
                    quiet ? 1'b1 : halted_q;

  // Simple mode transfer bookkeeping
  wire start_d = wr_len && !SG_PRESENT && may_start;
  assign issued_d = issued_q | start_d;
  assign active_d = start_d | (active_q & ~eng_sts.xfer_done);

  // Idle from the next-state halted so both never read one together
  wire sg_idle = eng_sts.tail_done;
  wire simple_idle = issued_d && !active_d &&
                     !eng_sts.mover_busy;
  assign idle_d = halted_d ? 1'b0 :
                  SG_PRESENT ? sg_idle : simple_idle;

  // Pointer side effects, blocked while frozen
  wire cur_load_d = wr_cur && SG_PRESENT && !frozen;
  wire resume_d = wr_tail && SG_PRESENT && !frozen;

  // Status flops; halted comes up set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= sms_pkg::CTL_RUN_RST;
      halted_q <= sms_pkg::STS_HALT_RST;
      idle_q <= sms_pkg::STS_IDLE_RST;
      issued_q <= 1'b0;
      active_q <= 1'b0;
    end
    else if (pce)
    begin
      run_q <= run_d;
      halted_q <= halted_d;
      idle_q <= idle_d;
      issued_q <= issued_d;
      active_q <= active_d;
    end
  end

  // One-cycle command pulses toward the engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      resume_q <= 1'b0;
      cur_load_q <= 1'b0;
      start_q <= 1'b0;
    end
    else if (pce)
    begin
      resume_q <= resume_d;
      cur_load_q <= cur_load_d;
      start_q <= start_d;
    end
  end

  // Pointer and length storage; values kept even when blocked
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_q <= sms_pkg::WORD_RST;
      tail_q <= sms_pkg::WORD_RST;
      len_q <= sms_pkg::WORD_RST;
    end
    else if (pce)
    begin
      if (wr_cur)
        cur_q <= pwdata;
      if (wr_tail)
        tail_q <= pwdata;
      if (wr_len)
        len_q <= pwdata;
    end
  end

  // Events: halted and idle rising, each error
  assign evt[sms_pkg::EVT_HALT] = halted_d && !halted_q;
  assign evt[sms_pkg::EVT_IDLE] = idle_d && !idle_q;
  assign evt[sms_pkg::EVT_INT_ERR] = eng_sts.err_int;
  assign evt[sms_pkg::EVT_SLV_ERR] = eng_sts.err_slv;

  // Status word; bit 2 and upward are wired to zero
  wire [sms_pkg::DATA_W-1:0] sts_word =
    {{(sms_pkg::DATA_W-2){1'b0}}, idle_q, halted_q};

  // Read mux
  assign rd_data =
    hit_ctl ? {{(sms_pkg::DATA_W-1){1'b0}}, run_q} :
    hit_sts ? sts_word :
    hit_cur ? cur_q :
    hit_tail ? tail_q :
    hit_len ? len_q :
    hit_isr ? {{(sms_pkg::DATA_W-sms_pkg::IRQ_W){1'b0}}, irq_sts} :
    hit_imr ? {{(sms_pkg::DATA_W-sms_pkg::IRQ_W){1'b0}}, irq_msk} :
    sms_pkg::WORD_RST;

  // Bus slave
  sms_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .hit(hit),
    .rd_data(rd_data),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_stb(wr_stb)
  );

  // Interrupt status and mask
  sms_irq #(.W(sms_pkg::IRQ_W)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .evt(evt),
    .clr_we(wr_isr),
    .mask_we(wr_imr),
    .wdata(pwdata[sms_pkg::IRQ_W-1:0]),
    .status(irq_sts),
    .mask(irq_msk),
    .irq(irq)
  );

  // Outputs to the engine
  assign eng_ctl.run = run_q;
  assign eng_ctl.sg_resume = resume_q;
  assign eng_ctl.cur_load = cur_load_q;
  assign eng_ctl.xfer_start = start_q;
  assign cur_ptr = cur_q;
  assign tail_ptr = tail_q;
  assign xfer_len = len_q;

  // Checks next to the logic they guard
  wire sts_setup = pce && psel && !penable && !pwrite && hit_sts;

  sts_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    sts_setup |=> prdata[sms_pkg::DATA_W-1:sms_pkg::STS_RSVD_BIT] == '0 &&
      prdata[sms_pkg::STS_HALT_BIT] == $past(halted_q))
    else $error("status read does not show halted or reserved bits");

  sts_nowrite_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && psel && penable && pwrite && hit_sts && !run_q && !quiet)
      |=> halted_q == $past(halted_q))
    else $error("status write changed halted flag");

  halt_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && !halted_q && !quiet) |=> !halted_q)
    else $error("halted set while engine still active");

  halt_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && err_any) ##1 (pce && quiet)[*2] |=> halted_q)
    else $error("halted not set after error wind-down");

  run_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && err_any) |=> !run_q)
    else $error("error did not clear run");

  halt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && run_q) |=> !halted_q)
    else $error("halted still set while running");

  ptr_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && frozen && (wr_cur || wr_tail)) |=> !resume_q && !cur_load_q)
    else $error("pointer write acted while halted");

  len_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && halted_q && wr_len) |=> !start_q)
    else $error("length write started transfer while halted");

  tail_kick_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && SG_PRESENT && wr_tail && idle_q && run_q) |=> resume_q)
    else $error("tail write did not resume idle channel");

  sg_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && SG_PRESENT && !eng_sts.tail_done) |=> !idle_q)
    else $error("idle set before tail reached");

  busy_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && !SG_PRESENT && (active_d || eng_sts.mover_busy)) |=> !idle_q)
    else $error("idle set while transfer in progress");

  halt_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    halted_q |-> !idle_q)
    else $error("idle and halted both set");

  first_xfer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!SG_PRESENT && !issued_q) |-> !idle_q)
    else $error("idle set before first transfer");

  // Main scenarios
  cov_halt_c: cover property (@(posedge pclk) disable iff (!presetn)
    !halted_q ##1 halted_q);
  cov_resume_c: cover property (@(posedge pclk) disable iff (!presetn)
    idle_q ##1 resume_q);
  cov_err_c: cover property (@(posedge pclk) disable iff (!presetn)
    run_q && err_any);
  cov_start_c: cover property (@(posedge pclk) disable iff (!presetn)
    start_q ##[1:20] idle_q);

endmodule : sms_status_top

// ---- inc/sms_pkg.sv ----
// Purpose: Shared constants and carriers for the stream-to-memory status block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses within the channel window
package sms_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CTL = 8'h30;
  localparam logic [7:0] OFF_STS = 8'h34;
  localparam logic [7:0] OFF_CUR = 8'h38;
  localparam logic [7:0] OFF_TAIL = 8'h40;
  localparam logic [7:0] OFF_LEN = 8'h58;
  localparam logic [7:0] OFF_IRQ_STS = 8'h60;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h64;

  // Field positions
  localparam int CTL_RUN_BIT = 0;
  localparam int STS_HALT_BIT = 0;
  localparam int STS_IDLE_BIT = 1;
  localparam int STS_RSVD_BIT = 2;

  // Reset values
  localparam logic CTL_RUN_RST = 1'b0;
  localparam logic STS_HALT_RST = 1'b1;
  localparam logic STS_IDLE_RST = 1'b0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Interrupt event bits
  localparam int IRQ_W = 4;
  localparam int EVT_HALT = 0;
  localparam int EVT_IDLE = 1;
  localparam int EVT_INT_ERR = 2;
  localparam int EVT_SLV_ERR = 3;

  // Engine status toward this block, same clock as pclk
  typedef struct packed {
    logic mover_busy;
    logic fetch_busy;
    logic tail_done;
    logic xfer_done;
    logic err_int;
    logic err_slv;
  } sms_eng_sts_s;

  // Control toward the engine, all from flip-flops
  typedef struct packed {
    logic run;
    logic sg_resume;
    logic cur_load;
    logic xfer_start;
  } sms_eng_ctl_s;

endpackage : sms_pkg

// ---- verif/sms_eng_model.sv ----
// Purpose: Behavioural engine on the far side of the status block
// Assumes: Control pulses one cycle wide on pclk
// Notes: Errors only when the bench asks through err_req
`timescale 1ns/1ps
module sms_eng_model #(
  parameter bit SG = 1'b1,
  parameter int DLY = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Block side
  input wire sms_pkg::sms_eng_ctl_s ctl,
  output sms_pkg::sms_eng_sts_s sts,
  // Bench command
  input wire logic err_req
);
  int cnt;
  wire logic go = SG ? ctl.sg_resume : ctl.xfer_start;

  // One transfer per start; mover busy, and fetch busy only when SG, until count runs out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts <= '0;
      cnt <= 0;
    end
    else
    begin
      sts.xfer_done <= 1'b0;
      // Internal errors exist only with the gather engine built in
      sts.err_int <= err_req && SG;
      sts.err_slv <= err_req && !SG;
      if (go)
      begin
        cnt <= DLY;
        sts.mover_busy <= 1'b1;
        sts.fetch_busy <= SG;
        sts.tail_done <= 1'b0;
      end
      else if (cnt == 1)
      begin
        cnt <= 0;
        sts.mover_busy <= 1'b0;
        sts.fetch_busy <= 1'b0;
        sts.xfer_done <= 1'b1;
        sts.tail_done <= SG;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule : sms_eng_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for both channel modes of the status block
// Assumes: Instance 0 scatter-gather, instance 1 simple mode
// Notes: Shared APB wires, one select per instance
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [1:0] psel = 2'b00;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] pready, pslverr, irq, err_req = 2'b00;
  logic [31:0] prdata [2];
  logic [31:0] tail_ptr [2], cur_ptr [2], xfer_len [2];
  logic pce = 1'b1;
  sms_pkg::sms_eng_sts_s sts [2];
  sms_pkg::sms_eng_ctl_s ctl [2];
  int bad_count = 0;
  int tests_run = 0;
  int starts [2] = '{0, 0};
  int cyc_cnt = 0;
  logic [31:0] r, r2;
  logic e;

  always #2.5 pclk = ~pclk;

  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    sms_status_top #(.SG_PRESENT(g == 0)) u_sms_status_top (
      .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel[g]),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready[g]), .pslverr(pslverr[g]), .prdata(prdata[g]),
      .eng_sts(sts[g]), .eng_ctl(ctl[g]), .cur_ptr(cur_ptr[g]),
      .tail_ptr(tail_ptr[g]), .xfer_len(xfer_len[g]), .irq(irq[g]));
    sms_eng_model #(.SG(g == 0), .DLY(14)) u_sms_eng_model (
      .pclk(pclk), .presetn(presetn), .ctl(ctl[g]), .sts(sts[g]),
      .err_req(err_req[g]));
    // Count every start pulse the block issues
    always @(posedge pclk)
      starts[g] += int'(ctl[g].sg_resume | ctl[g].xfer_start);
  end

  // Hang guard, well above the whole run
  always @(posedge pclk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] x, logic [31:0] y);
    tests_run++;
    if (x !== y)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, y);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input int i, input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel[i] <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready[i] !== 1'b1);
    r = prdata[i];
    e = pslverr[i];
    psel[i] <= 1'b0;
    penable <= 1'b0;
    // Let an edge pass so the next call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb

  // Start one transfer in the mode of instance i
  task automatic kick(input int i);
    apb(i, 1'b1, i == 0 ? sms_pkg::OFF_TAIL : sms_pkg::OFF_LEN, 32'h100);
  endtask : kick

  initial
  begin
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    for (int i = 0; i < 2; i++)
    begin
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts reset", 32'h1, r);
      apb(i, 1, sms_pkg::OFF_STS, 32'hFFFF_FFFF);
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts after write", 32'h1, r);
      apb(i, 1, sms_pkg::OFF_CUR, 32'h80);
      kick(i);
      cyc(20);
      chk("starts halted", 0, starts[i]);
      chk("cur stored", 32'h80, cur_ptr[i]);
      chk("kick stored", 32'h100, i == 0 ? tail_ptr[i] : xfer_len[i]);
      apb(i, 1, sms_pkg::OFF_CTL, 32'h1);
      cyc(3);
      // Setup edge frozen by the clock enable: data must still be fresh
      pce <= 1'b0;
      fork
        apb(i, 0, sms_pkg::OFF_STS, 0);
        begin
          cyc(3);
          pce <= 1'b1;
        end
      join
      chk("frozen read", 32'h0, r);
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts running", 32'h0, r);
      kick(i);
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts busy", 32'h0, r);
      cyc(20);
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts done", 32'h2, r);
      chk("starts run", 1, starts[i]);
      // Stop while the mover is still busy: halt must wait for it
      kick(i);
      apb(i, 1, sms_pkg::OFF_CTL, 32'h0);
      apb(i, 1, sms_pkg::OFF_STS, 32'hFFFF_FFFF);
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts stopping", 32'h0, r);
      cyc(20);
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts stopped", 32'h1, r);
      // Error while running stops the channel on its own
      apb(i, 1, sms_pkg::OFF_CTL, 32'h1);
      cyc(3);
      err_req[i] <= 1'b1;
      cyc(1);
      err_req[i] <= 1'b0;
      cyc(10);
      apb(i, 0, sms_pkg::OFF_CTL, 0);
      chk("run after error", 32'h0, r & 32'h1);
      apb(i, 0, sms_pkg::OFF_STS, 0);
      chk("sts after error", 32'h1, r);
      // Interrupt: event seen, mask changes output, write one clears
      apb(i, 0, sms_pkg::OFF_IRQ_STS, 0);
      chk("halt event", 32'h1, r & 32'h1);
      chk("err event", i == 0 ? 32'h4 : 32'h8, r & 32'hC);
      apb(i, 1, sms_pkg::OFF_IRQ_MSK, 32'h0);
      cyc(1);
      r2 = {31'h0, irq[i]};
      apb(i, 1, sms_pkg::OFF_IRQ_MSK, 32'hF);
      cyc(1);
      chk("irq mask effect", 32'h1, r2 ^ {31'h0, irq[i]});
      apb(i, 1, sms_pkg::OFF_IRQ_STS, 32'hF);
      cyc(1);
      apb(i, 0, sms_pkg::OFF_IRQ_STS, 0);
      chk("irq sts cleared", 32'h0, r);
      chk("irq low", 32'h0, {31'h0, irq[i]});
      apb(i, 0, 8'hFC, 0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
    end
    finish_test();
  end
endmodule : testbench
